// *** shared/tdcp_pkg.sv ***
package tdcp_pkg;

  // word framing
  localparam int WORD_BITS = 16;
  localparam int CHANNELS  = 6;
  localparam int LEN_W     = 3;

  // serial clock: system cycles per half period of the serial clock
  localparam int SCLK_HALF_DEF = 4;

  // sample period in serial clock periods
  localparam logic [15:0] PERIOD_BITS_DEF = 16'h0400;

  // wishbone byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_POWER     = 8'h04;
  localparam logic [7:0] OFS_PERIOD    = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_LAST_WORD = 8'h10;
  localparam logic [2:0] OFS_SAMPLE_HI = 3'h1;

  // control register fields
  localparam int CTRL_DNP_BIT  = 0;
  localparam int CTRL_MM_BIT   = 1;
  localparam int CTRL_LEN_LSB  = 2;
  localparam int CTRL_SRST_BIT = 7;
  localparam int CTRL_W        = 5;
  localparam logic [4:0] CTRL_DEF  = 5'h00;
  localparam logic [5:0] POWER_DEF = 6'h00;

  // serial control word fields
  localparam int CW_FLAG_BIT = 15;
  localparam int CW_REG_LSB  = 11;
  localparam int CW_ADDR_LSB = 8;
  localparam logic [3:0] CW_REG_CTRL  = 4'h0;
  localparam logic [3:0] CW_REG_POWER = 4'h1;
  localparam logic [2:0] ADDR_SELF    = 3'h0;

  typedef enum logic [0:0] {TDCP_IDLE, TDCP_SLOT} tdcp_state_t;

endpackage

// *** hdl/tdcp_sclk_gen.sv ***
`timescale 1ns/10ps
module tdcp_sclk_gen #(
  parameter int HALF = tdcp_pkg::SCLK_HALF_DEF
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic run_in,
  // serial clock and edge markers
  output logic      sclk_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic [7:0] cnt_reg;
  logic       sclk_reg;
  logic       wrap;

  assign wrap     = run_in && (cnt_reg == 8'(HALF - 1));
  assign rise_out = wrap && !sclk_reg;
  assign fall_out = wrap && sclk_reg;
  assign sclk_out = sclk_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 8'h00;
      sclk_reg <= 1'b0;
    end else if (!run_in) begin
      cnt_reg  <= 8'h00;
      sclk_reg <= 1'b0;
    end else if (wrap) begin
      cnt_reg  <= 8'h00;
      sclk_reg <= !sclk_reg;
    end else begin
      cnt_reg  <= cnt_reg + 8'h01;
    end
  end

endmodule

// *** hdl/tdcp_rx.sv ***
`timescale 1ns/10ps
module tdcp_rx (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // sample point (serial clock falling)
  input  wire logic        sample_in,
  // raw pins
  input  wire logic        data_raw_in,
  input  wire logic        frame_raw_in,
  // results
  output logic             data_bit_out,
  output logic [15:0]      word_out,
  output logic             valid_out
);

  logic        d_meta_reg;
  logic        d_sync_reg;
  logic        f_meta_reg;
  logic        f_sync_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] shift_reg;

  assign data_bit_out = d_sync_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      d_meta_reg <= 1'b0;
      d_sync_reg <= 1'b0;
      f_meta_reg <= 1'b0;
      f_sync_reg <= 1'b0;
    end else begin
      d_meta_reg <= data_raw_in;
      d_sync_reg <= d_meta_reg;
      f_meta_reg <= frame_raw_in;
      f_sync_reg <= f_meta_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg   <= 5'h00;
      shift_reg <= 16'h0000;
      word_out  <= 16'h0000;
      valid_out <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      if (sample_in) begin
        if (cnt_reg != 5'h00) begin
          shift_reg <= {shift_reg[14:0], d_sync_reg};
          cnt_reg   <= cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            word_out  <= {shift_reg[14:0], d_sync_reg};
            valid_out <= 1'b1;
          end
        end
        if (f_sync_reg) begin
          cnt_reg <= 5'(tdcp_pkg::WORD_BITS);
        end
      end
    end
  end

endmodule

// *** hdl/tdcp_port.sv ***
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - active-high pulse one bit before word
// - device generates serial clock output
// - direct: output pulse loops to input
// - up to eight devices, address selects
// - cascade length field, reset zero, times slots
// - per channel, devices output in turn
// - extra bit; next pulse during it
// - output pair feeds next device input
// - serial clocks share frequency and phase
// - address zero accepted, else decrement, forward
// - mixed: msb flags control, data msb zero
// - powered-down slot leaves output undriven
// - data mode ignores input until reset
module tdcp_port #(
  parameter int SCLK_HALF = tdcp_pkg::SCLK_HALF_DEF
) (
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  // wishbone slave
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [31:0] WB_DAT_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // serial link
  input  wire logic        PORT_ENABLE_IN,
  input  wire logic        SERIAL_WORD_IN,
  input  wire logic        INPUT_FRAME_PULSE_IN,
  output logic             SERIAL_CLOCK_OUT,
  output logic             SERIAL_WORD_OUT,
  output logic             SERIAL_WORD_OE_OUT,
  output logic             OUTPUT_FRAME_PULSE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  logic                      en_meta_reg;
  logic                      en_sync_reg;
  logic                      rise;
  logic                      fall;
  logic                      rx_bit;
  logic [15:0]               rx_word;
  logic                      rx_valid;
  logic [tdcp_pkg::CTRL_W-1:0] ctrl_reg;
  logic [5:0]                power_reg;
  logic [15:0]               period_reg;
  logic [15:0]               period_cnt_reg;
  logic [15:0]               last_word_reg;
  logic [15:0]               sample_mem [tdcp_pkg::CHANNELS];
  logic [15:0]               fwd_word_reg;
  logic                      fwd_pending_reg;
  logic [15:0]               tx_shift_reg;
  tdcp_pkg::tdcp_state_t     state_reg;
  tdcp_pkg::tdcp_state_t     state_next;
  logic [2:0]                chan_reg;
  logic [2:0]                chan_next;
  logic [7:0]                bit_reg;
  logic [7:0]                bit_next;
  logic [7:0]                slot_last;
  logic                      dnp;
  logic                      mm;
  logic                      data_locked;
  logic [2:0]                len;
  logic                      ctl_word;
  logic                      accept;
  logic                      forward;
  logic                      wb_req;
  logic                      wb_wr;
  logic                      srst;
  logic                      load_own;

  assign dnp         = ctrl_reg[tdcp_pkg::CTRL_DNP_BIT];
  assign mm          = ctrl_reg[tdcp_pkg::CTRL_MM_BIT];
  assign len         = ctrl_reg[tdcp_pkg::CTRL_LEN_LSB +: tdcp_pkg::LEN_W];
  assign data_locked = dnp && !mm;
  // slot spans own word plus upstream words
  assign slot_last   = {({1'b0, len} + 4'h1), 4'h0};

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [1:0] sel);
    merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= PORT_ENABLE_IN;
      en_sync_reg <= en_meta_reg;
    end
  end

  tdcp_sclk_gen #(.HALF(SCLK_HALF)) u_sclk (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .run_in   (en_sync_reg),
    .sclk_out (SERIAL_CLOCK_OUT),
    .rise_out (rise),
    .fall_out (fall)
  );

  // input framing works looped back or independent
  tdcp_rx u_rx (
    .clk_in       (CLOCK_IN),
    .rst_n_in     (RST_N_IN),
    .sample_in    (fall),
    .data_raw_in  (SERIAL_WORD_IN),
    .frame_raw_in (INPUT_FRAME_PULSE_IN),
    .data_bit_out (rx_bit),
    .word_out     (rx_word),
    .valid_out    (rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data mode ignores words; flag bit in mixed
  assign ctl_word = rx_valid && (!dnp || (mm && rx_word[tdcp_pkg::CW_FLAG_BIT]));
  assign accept   = ctl_word && (rx_word[tdcp_pkg::CW_ADDR_LSB +: 3] == tdcp_pkg::ADDR_SELF);
  assign forward  = ctl_word && !accept;

  assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign wb_wr  = wb_req && WB_WE_IN;
  assign srst   = wb_wr && (WB_ADR_IN == tdcp_pkg::OFS_CTRL) && WB_SEL_IN[0]
                  && WB_DAT_IN[tdcp_pkg::CTRL_SRST_BIT] && !data_locked;

  // control state: soft reset wins, then serial word, then bus write
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_reg   <= tdcp_pkg::CTRL_DEF;
      power_reg  <= tdcp_pkg::POWER_DEF;
      period_reg <= tdcp_pkg::PERIOD_BITS_DEF;
    end else if (srst) begin
      ctrl_reg   <= tdcp_pkg::CTRL_DEF;
      power_reg  <= tdcp_pkg::POWER_DEF;
      period_reg <= tdcp_pkg::PERIOD_BITS_DEF;
    end else if (accept) begin
      if (rx_word[tdcp_pkg::CW_REG_LSB +: 4] == tdcp_pkg::CW_REG_CTRL) begin
        ctrl_reg <= rx_word[tdcp_pkg::CTRL_W-1:0];
      end else if (rx_word[tdcp_pkg::CW_REG_LSB +: 4] == tdcp_pkg::CW_REG_POWER) begin
        power_reg <= rx_word[5:0];
      end
    end else if (wb_wr && !data_locked) begin
      if (WB_ADR_IN == tdcp_pkg::OFS_CTRL && WB_SEL_IN[0]) begin
        ctrl_reg <= WB_DAT_IN[tdcp_pkg::CTRL_W-1:0];
      end else if (WB_ADR_IN == tdcp_pkg::OFS_POWER && WB_SEL_IN[0]) begin
        power_reg <= WB_DAT_IN[5:0];
      end else if (WB_ADR_IN == tdcp_pkg::OFS_PERIOD) begin
        period_reg <= merge(period_reg, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
      end
    end
  end

  // converter words stand in a small array
  always_ff @(posedge CLOCK_IN) begin
    if (wb_wr && WB_ADR_IN[7:5] == tdcp_pkg::OFS_SAMPLE_HI && WB_ADR_IN[4:2] < 3'h6) begin
      sample_mem[WB_ADR_IN[4:2]] <= merge(sample_mem[WB_ADR_IN[4:2]], WB_DAT_IN[15:0],
                                          WB_SEL_IN[1:0]);
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      last_word_reg   <= 16'h0000;
      fwd_word_reg    <= 16'h0000;
      fwd_pending_reg <= 1'b0;
    end else begin
      if (accept) begin
        last_word_reg <= rx_word;
      end
      // decrement address and pass on; set wins over clear
      if (forward) begin
        fwd_word_reg    <= {rx_word[15:11], rx_word[10:8] - 3'h1, rx_word[7:0]};
        fwd_pending_reg <= 1'b1;
      end else if (load_own) begin
        fwd_pending_reg <= 1'b0;
      end
    end
  end

  // wishbone answer one cycle after request
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        case (WB_ADR_IN)
          tdcp_pkg::OFS_CTRL:      WB_DAT_OUT <= {27'h0, ctrl_reg};
          tdcp_pkg::OFS_POWER:     WB_DAT_OUT <= {26'h0, power_reg};
          tdcp_pkg::OFS_PERIOD:    WB_DAT_OUT <= {16'h0, period_reg};
          tdcp_pkg::OFS_STATUS:    WB_DAT_OUT <= {26'h0, chan_reg, state_reg,
                                                  fwd_pending_reg, en_sync_reg};
          tdcp_pkg::OFS_LAST_WORD: WB_DAT_OUT <= {16'h0, last_word_reg};
          default: begin
            if (WB_ADR_IN[7:5] == tdcp_pkg::OFS_SAMPLE_HI && WB_ADR_IN[4:2] < 3'h6) begin
              WB_DAT_OUT <= {16'h0, sample_mem[WB_ADR_IN[4:2]]};
            end else begin
              WB_DAT_OUT <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot sequencer, advanced at each serial clock rise
  always_comb begin
    state_next = state_reg;
    chan_next  = chan_reg;
    bit_next   = bit_reg;
    if (rise) begin
      case (state_reg)
        tdcp_pkg::TDCP_IDLE: begin
          if (period_cnt_reg == 16'h0000) begin
            state_next = tdcp_pkg::TDCP_SLOT;
            chan_next  = 3'h0;
            bit_next   = 8'h00;
          end
        end
        tdcp_pkg::TDCP_SLOT: begin
          // next channel after every device's word
          if (bit_reg == slot_last) begin
            bit_next = 8'h00;
            if (chan_reg == 3'(tdcp_pkg::CHANNELS - 1)) begin
              state_next = tdcp_pkg::TDCP_IDLE;
            end else begin
              chan_next = chan_reg + 3'h1;
            end
          end else begin
            bit_next = bit_reg + 8'h01;
          end
        end
        default: state_next = tdcp_pkg::TDCP_IDLE;
      endcase
    end
  end

  assign load_own = rise && state_next == tdcp_pkg::TDCP_SLOT && bit_next == 8'h00;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg      <= tdcp_pkg::TDCP_IDLE;
      chan_reg       <= 3'h0;
      bit_reg        <= 8'h00;
      period_cnt_reg <= 16'h0000;
    end else if (!en_sync_reg) begin
      state_reg      <= tdcp_pkg::TDCP_IDLE;
      chan_reg       <= 3'h0;
      bit_reg        <= 8'h00;
      period_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      chan_reg  <= chan_next;
      bit_reg   <= bit_next;
      if (rise) begin
        period_cnt_reg <= (period_cnt_reg >= period_reg - 16'h0001) ? 16'h0000
                          : period_cnt_reg + 16'h0001;
      end
    end
  end

  // line drivers, updated with the serial clock rise
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OUTPUT_FRAME_PULSE_OUT <= 1'b0;
      SERIAL_WORD_OUT        <= 1'b0;
      SERIAL_WORD_OE_OUT     <= 1'b0;
      tx_shift_reg           <= 16'h0000;
    end else if (!en_sync_reg) begin
      OUTPUT_FRAME_PULSE_OUT <= 1'b0;
      SERIAL_WORD_OUT        <= 1'b0;
      SERIAL_WORD_OE_OUT     <= 1'b0;
    end else if (rise) begin
      if (state_next != tdcp_pkg::TDCP_SLOT) begin
        OUTPUT_FRAME_PULSE_OUT <= 1'b0;
        SERIAL_WORD_OUT        <= 1'b0;
        SERIAL_WORD_OE_OUT     <= 1'b0;
      end else begin
        // idle slot leaves the line undriven
        SERIAL_WORD_OE_OUT <= power_reg[chan_next];
        if (bit_next == 8'h00) begin
          // pulse rides on the extra bit
          OUTPUT_FRAME_PULSE_OUT <= power_reg[chan_next];
          SERIAL_WORD_OUT        <= 1'b0;
          // data words carry a zero flag bit when dnp is set
          if (fwd_pending_reg) begin
            tx_shift_reg <= fwd_word_reg;
          end else if (dnp) begin
            tx_shift_reg <= {1'b0, sample_mem[chan_next][14:0]};
          end else begin
            tx_shift_reg <= sample_mem[chan_next];
          end
        end else if (bit_next <= 8'(tdcp_pkg::WORD_BITS)) begin
          OUTPUT_FRAME_PULSE_OUT <= 1'b0;
          SERIAL_WORD_OUT        <= tx_shift_reg[15];
          tx_shift_reg           <= {tx_shift_reg[14:0], 1'b0};
        end else begin
          OUTPUT_FRAME_PULSE_OUT <= 1'b0;
          SERIAL_WORD_OUT        <= rx_bit;
        end
      end
    end else if (!power_reg[chan_reg]) begin
      SERIAL_WORD_OE_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  localparam int HALF2 = 2 * SCLK_HALF;
  logic [7:0] frame_len_reg;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frame_len_reg <= 8'h00;
    end else begin
      frame_len_reg <= OUTPUT_FRAME_PULSE_OUT ? frame_len_reg + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  AST_FRAME_ONE_BIT: assert property (frame_len_reg <= 8'(HALF2))
    else $error("output frame pulse longer than one bit");
  AST_SCLK_TOGGLE: assert property (rise |=> SERIAL_CLOCK_OUT)
    else $error("serial clock did not rise");
  AST_FRAME_BEFORE_WORD: assert property (
    rise && OUTPUT_FRAME_PULSE_OUT |=> !OUTPUT_FRAME_PULSE_OUT && bit_reg == 8'h01)
    else $error("word did not follow frame pulse");
  AST_SLOT_LENGTH: assert property (
    rise && state_reg == tdcp_pkg::TDCP_SLOT && bit_reg == slot_last |=> bit_reg == 8'h00)
    else $error("slot length wrong for cascade length");
  AST_CHANNEL_ORDER: assert property (
    rise && bit_reg == slot_last && chan_reg < 3'h5 && state_reg == tdcp_pkg::TDCP_SLOT
    |=> chan_reg == $past(chan_reg) + 3'h1)
    else $error("channel order broken");
  AST_HIZ_UNPOWERED: assert property (
    SERIAL_WORD_OE_OUT |-> state_reg == tdcp_pkg::TDCP_SLOT
    && (((power_reg | $past(power_reg)) >> chan_reg) & 6'h01) != 6'h00)
    else $error("driving line in unpowered slot");
  AST_DATA_LOCK: assert property (
    data_locked |=> $stable(ctrl_reg) && $stable(power_reg))
    else $error("control changed in data mode");
  AST_FORWARD_ADDR: assert property (
    forward |=> fwd_pending_reg && fwd_word_reg[10:8] == $past(rx_word[10:8]) - 3'h1)
    else $error("forwarded word address not decremented");
  AST_DATA_MSB_ZERO: assert property (
    load_own && dnp && !fwd_pending_reg |=> !tx_shift_reg[15])
    else $error("data word flag bit set");
  AST_PASS_THROUGH: assert property (
    rise && state_next == tdcp_pkg::TDCP_SLOT && bit_next > 8'(tdcp_pkg::WORD_BITS)
    |=> SERIAL_WORD_OUT == $past(rx_bit))
    else $error("upstream bit not passed through");

  COV_FRAME: cover property (rise && OUTPUT_FRAME_PULSE_OUT);
  COV_ACCEPT: cover property (accept);
  COV_FORWARD: cover property (forward ##[1:1000] load_own);
  COV_MIXED: cover property (mm && dnp && accept);

endmodule

// *** testbench/tdcp_dsp_model.sv ***
`timescale 1ns/10ps
module tdcp_dsp_model (
  // serial link
  input  wire logic sclk_in,
  input  wire logic rx_data_in,
  input  wire logic rx_frame_in,
  input  wire logic direct_in,
  output logic      tx_data_out,
  output logic      tx_frame_out
);
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;
  logic        fs_seen = 1'b0;
  logic        seen    = 1'b0;
  int          rx_cnt  = 0;
  int          tx_cnt  = 0;
  int          gap     = 0;
  int          min_gap = 9999;

  initial tx_data_out = 1'b0;
  initial tx_frame_out = 1'b0;

  task automatic send(input logic [15:0] w);
    tx_q.push_back(w);
  endtask

  task automatic clear_gap();
    seen = 1'b0;
    min_gap = 9999;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // capture at falls
  always @(negedge sclk_in) begin
    gap = gap + 1;
    fs_seen = rx_frame_in;
    if (rx_cnt > 0) begin
      rx_sh = {rx_sh[14:0], rx_data_in};
      rx_cnt = rx_cnt - 1;
      if (rx_cnt == 0) rx_q.push_back(rx_sh);
    end
    if (rx_frame_in) begin
      if (seen && gap < min_gap) min_gap = gap;
      seen = 1'b1;
      gap = 0;
      rx_cnt = 16;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // own or looped frame
  always @(posedge sclk_in) begin
    logic nd;
    logic nf;
    nd = ~tx_data_out;
    nf = 1'b0;
    if (tx_cnt > 0) begin
      nd = tx_sh[15];
      tx_sh = tx_sh << 1;
      tx_cnt = tx_cnt - 1;
    end
    if (tx_cnt == 0 && tx_q.size() > 0 && !direct_in) begin
      tx_sh = tx_q.pop_front();
      tx_cnt = 16;
      nf = 1'b1;
    end else if (tx_cnt == 0 && tx_q.size() > 0 && fs_seen) begin
      tx_sh = tx_q.pop_front();
      nd = tx_sh[15];
      tx_sh = tx_sh << 1;
      tx_cnt = 15;
    end
    tx_data_out <= nd;
    tx_frame_out <= nf;
  end
endmodule

// *** testbench/tdcp_port_test.sv ***
`timescale 1ns/10ps
module tdcp_port_test;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [31:0] wdat   = 32'h0;
  logic        we     = 1'b0;
  logic        cyc    = 1'b0;
  logic        en     = 1'b0;
  logic        direct = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        sclk;
  logic        serial_word_out;
  logic        sdo_oe;
  logic        ofs;
  logic        tx_d;
  logic        tx_f;
  logic [31:0] v;
  bit          found;
  bit          msb0;
  int          err_count    = 0;
  int          total_checks = 0;
  wire         ifs     = direct ? ofs : tx_f;
  wire         rx_line = sdo_oe ? serial_word_out : ~sclk;

  always #12.5 clk = ~clk;

  tdcp_port #(.SCLK_HALF(4)) dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(4'h3),
    .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .PORT_ENABLE_IN(en), .SERIAL_WORD_IN(tx_d), .INPUT_FRAME_PULSE_IN(ifs),
    .SERIAL_CLOCK_OUT(sclk), .SERIAL_WORD_OUT(serial_word_out), .SERIAL_WORD_OE_OUT(sdo_oe),
    .OUTPUT_FRAME_PULSE_OUT(ofs));
  tdcp_dsp_model dsp (.sclk_in(sclk), .rx_data_in(rx_line), .rx_frame_in(ofs),
    .direct_in(direct), .tx_data_out(tx_d), .tx_frame_out(tx_f));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] samp(input int c);
    return 16'h8a50 + 16'(c) * 16'h0111;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= {16'h0000, d};
    we <= w;
    cyc <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    v = rdat;
    if (n >= 40) err_count++;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 16'h0000);
    check(what, v, exp);
  endtask

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (dsp.rx_q.size() < n && k < 40000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 40000) err_count++;
  endtask

  // last bit, sync and apply
  task automatic wait_tx();
    int k;
    k = 0;
    while ((dsp.tx_q.size() > 0 || dsp.tx_cnt > 0) && k < 40000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 40000) err_count++;
    repeat (20) @(posedge clk);
  endtask

  task automatic send(input logic [15:0] w);
    dsp.send(w);
    wait_tx();
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1500000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h04, 32'h0, "power");
    rd(8'h08, {16'h0, tdcp_pkg::PERIOD_BITS_DEF}, "period");
    rd(8'h3c, 32'h0, "unmapped");
    rd(8'h0c, 32'h0, "status");
    for (int i = 0; i < 6; i++) wb(1'b1, 8'h20 + 8'(4 * i), samp(i));
    rd(8'h24, {16'h0, samp(1)}, "sample");
    wb(1'b1, 8'h08, 16'h0080);
    wb(1'b1, 8'h04, 16'h0015); // same set on every device
    // enable from output, synchronous to clock
    en <= 1'b1;
    wait_rx(3);
    for (int i = 0; i < 3; i++) check("word", dsp.rx_q[i], samp(2 * i));
    dsp.clear_gap();
    wait_rx(9);
    check("gap", dsp.min_gap, 34);
    send(16'h083f);
    rd(8'h04, 32'h3f, "power");
    rd(8'h10, 32'h083f, "last word");
    dsp.rx_q.delete();
    send(16'h0a01);
    rd(8'h04, 32'h3f, "power");
    wait_rx(12);
    found = 0;
    foreach (dsp.rx_q[j]) if (dsp.rx_q[j] === 16'h0901) found = 1;
    check("forward", found, 1);
    wb(1'b1, 8'h00, 16'h001c);
    rd(8'h00, 32'h1c, "length");
    wb(1'b1, 8'h08, 16'h0100);
    wb(1'b1, 8'h00, 16'h0004);
    wait_rx(dsp.rx_q.size() + 7);
    dsp.clear_gap();
    wait_rx(dsp.rx_q.size() + 7);
    check("gap", dsp.min_gap, 33);
    wb(1'b1, 8'h00, 16'h0007);
    wait_rx(dsp.rx_q.size() + 2);
    dsp.rx_q.delete();
    wait_rx(12);
    found = 0;
    msb0 = 1;
    foreach (dsp.rx_q[j]) begin
      if (dsp.rx_q[j] === 16'h0a50) found = 1;
      if (dsp.rx_q[j][15] !== 1'b0) msb0 = 0;
    end
    check("data msb", msb0, 1);
    check("ch0 data", found, 1);
    send(16'h0805);
    rd(8'h04, 32'h3f, "power");
    // control word sent within the period
    send(16'h8805);
    rd(8'h04, 32'h05, "power");
    wb(1'b1, 8'h00, 16'h0087);
    rd(8'h04, 32'h0, "soft reset power");
    rd(8'h08, {16'h0, tdcp_pkg::PERIOD_BITS_DEF}, "soft reset period");
    wb(1'b1, 8'h04, 16'h0005);
    wb(1'b1, 8'h00, 16'h0005);
    rd(8'h00, 32'h05, "ctrl");
    wb(1'b1, 8'h04, 16'h003f);
    send(16'h8811);
    rd(8'h04, 32'h05, "power");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    // direct coupling for a control word after reset
    direct <= 1'b1;
    dsp.send(16'h0803);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0, "ctrl");
    wb(1'b1, 8'h08, 16'h0080);
    wb(1'b1, 8'h04, 16'h0001);
    wait_tx();
    rd(8'h04, 32'h03, "power");
    tally_and_finish();
  end
endmodule
